// file: verilog/cttc_top.sv
// calendar timer control: run handshake, time counting, compare mode, interrupts
// How it works
// - compare interrupt only when its enable set
// - start sets running flag within two ticks
// - stop clears running flag within two ticks
// - stopped means run request and running zero
// - busy flag high about 62.5 ms per update
// - time registers all update together in one cycle
// - request flag set on each timer request
// - soft clear one then zero resets time, enables and control bits
// - periodic requests on each field update
// - compare match wraps counter to zero
`include "cttc_map.svh"
module cttc_top #(
  parameter int unsigned BUSY_CYCLES = `CTTC_BUSY_CYCLES,
  parameter int unsigned SEC_DIV     = 32'd256
) (
  // clock, reset, enable
  input  wire logic                  sys_clk,
  input  wire logic                  srst,
  input  wire logic                  clk_en,
  // count source ticks, one per source, synchronous to sys_clk
  input  wire logic [3:0]            src_ticks,
  // register port
  input  wire cttc_pkg::cttc_req_t   reg_req,
  output logic [7:0]                 reg_rdata,
  // interrupt
  output logic                       irq
);
  typedef struct packed {
    logic [7:0]          sec;
    logic [7:0]          min;
    logic [7:0]          hr;
    logic [2:0]          wk;
    logic                pm;
    logic                h24;
    logic                timing;
    logic                run_req;
    logic                running;
    logic                softclr;
    logic [7:0]          pie;
    logic [3:0]          src;
    logic                req_flag;
    logic                busy;
    logic [31:0]         busy_cnt;
    cttc_pkg::cttc_run_t phase;
    logic [5:0]          status;
    logic [5:0]          mask;
    logic [7:0]          rdata;
    logic                irq;
  } cttc_state_t;

  cttc_state_t         s_q;
  cttc_state_t         s_d;
  cttc_pkg::cttc_evt_t ev;
  logic                src_tick;
  logic                cnt_tick;
  logic                clr;
  logic                stopped;
  logic                rtc_mode;
  logic [7:0]          c1_rd;
  logic [7:0]          ic_rd;

  // ==========================================================================
  // prescaler
  cttc_prescale #(
    .SEC_DIV (SEC_DIV)
  ) u_pre (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .clk_en    (clk_en),
    .clr       (clr),
    .run       (s_q.running),
    .src_sel   (s_q.src),
    .src_ticks (src_ticks),
    .src_tick  (src_tick),
    .cnt_tick  (cnt_tick)
  );

  // BCD increment with wrap at lim
  function automatic logic [7:0] cttc_bcd_inc(input logic [7:0] v, input logic [7:0] lim);
    logic [7:0] r;
    r = v;
    if (v == lim) begin
      r = 8'h00;
    end else if (v[3:0] == 4'h9) begin
      r = {v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {v[7:4], v[3:0] + 4'h1};
    end
    return r;
  endfunction : cttc_bcd_inc

  // ==========================================================================
  // decoded helpers
  always_comb begin
    clr      = s_q.softclr && reg_req.wr && (reg_req.addr == `CTTC_CTRL_ONE_OFS)
               && !reg_req.wdata[`CTTC_C1_SOFTCLR_BIT];
    stopped  = !s_q.run_req && !s_q.running;
    rtc_mode = s_q.src[`CTTC_SRC_RTC_BIT];
    c1_rd    = {s_q.run_req, s_q.h24, s_q.pm, s_q.softclr, s_q.timing, 1'b0, s_q.running, 1'b0};
    ic_rd    = '0;
    ic_rd[`CTTC_IC_REQ_BIT]  = s_q.req_flag;
    ic_rd[`CTTC_IC_BUSY_BIT] = s_q.busy;
  end

  // ==========================================================================
  // next state
  always_comb begin
    s_d = s_q;
    ev  = '0;
    // run handshake, settles within two source ticks
    case (s_q.phase)
      cttc_pkg::CTTC_STOPPED: begin
        if (s_q.run_req) begin
          s_d.phase  = cttc_pkg::CTTC_STARTING;
        end
      end
      cttc_pkg::CTTC_STARTING: begin
        if (src_tick) begin
          s_d.running = 1'b1;
          s_d.phase   = cttc_pkg::CTTC_RUNNING;
        end
      end
      cttc_pkg::CTTC_RUNNING: begin
        if (!s_q.run_req) begin
          s_d.phase = cttc_pkg::CTTC_STOPPING;
        end
      end
      cttc_pkg::CTTC_STOPPING: begin
        if (src_tick) begin
          s_d.running = 1'b0;
          s_d.phase   = cttc_pkg::CTTC_STOPPED;
        end
      end
      default: begin
        s_d.phase = cttc_pkg::CTTC_STOPPED;
      end
    endcase

    // counting: fields roll together in one cycle, as a set
    if (s_q.running && cnt_tick) begin
      if (rtc_mode) begin
        s_d.sec = cttc_bcd_inc(s_q.sec, 8'h59);
        ev.sec  = 1'b1;
        if (s_q.sec == 8'h59) begin
          s_d.min = cttc_bcd_inc(s_q.min, 8'h59);
          ev.min  = 1'b1;
          if (s_q.min == 8'h59) begin
            ev.hr = 1'b1;
            if (s_q.h24) begin
              s_d.hr = cttc_bcd_inc(s_q.hr, 8'h23);
            end else begin
              s_d.hr = cttc_bcd_inc(s_q.hr, 8'h11);
              if (s_q.hr == 8'h11) begin
                s_d.pm = ~s_q.pm;
              end
            end
            if ((s_q.h24 && s_q.hr == 8'h23) || (!s_q.h24 && s_q.hr == 8'h11 && s_q.pm)) begin
              s_d.wk = (s_q.wk == 3'd6) ? 3'd0 : s_q.wk + 3'd1;
              ev.day = 1'b1;
              ev.wk  = (s_q.wk == 3'd6);
            end
          end
        end
        // update window opens on each seconds update
        s_d.busy     = 1'b1;
        s_d.busy_cnt = '0;
      end else begin
        // compare mode: seconds holds counter, minutes holds compare value
        if (s_q.sec == s_q.min) begin
          s_d.sec = 8'h00;
          ev.cmp  = 1'b1;
        end else begin
          s_d.sec = s_q.sec + 8'h01;
        end
      end
    end

    // busy window countdown
    if (s_q.busy && !(s_q.running && cnt_tick && rtc_mode)) begin
      if (s_q.busy_cnt == BUSY_CYCLES - 32'd1) begin
        s_d.busy = 1'b0;
      end else begin
        s_d.busy_cnt = s_q.busy_cnt + 32'd1;
      end
    end

    // register reads; read of status clears it
    s_d.rdata = 8'h00;
    if (reg_req.rd) begin
      case (reg_req.addr)
        `CTTC_SECONDS_OFS:    s_d.rdata = s_q.sec;
        `CTTC_MINUTES_OFS:    s_d.rdata = s_q.min;
        `CTTC_HOURS_OFS:      s_d.rdata = s_q.hr;
        `CTTC_WEEKDAY_OFS:    s_d.rdata = {5'h00, s_q.wk};
        `CTTC_CTRL_ONE_OFS:   s_d.rdata = c1_rd;
        `CTTC_PIE_OFS:        s_d.rdata = s_q.pie & `CTTC_PIE_WR_MASK;
        `CTTC_SRC_SEL_OFS:    s_d.rdata = {4'h0, s_q.src};
        `CTTC_IRQ_CTRL_OFS: begin
          s_d.rdata    = ic_rd;
          s_d.req_flag = 1'b0;
        end
        `CTTC_IRQ_STATUS_OFS: begin
          s_d.rdata  = {2'b00, s_q.status};
          s_d.status = '0;
        end
        `CTTC_IRQ_MASK_OFS:   s_d.rdata = {2'b00, s_q.mask};
        default:              s_d.rdata = 8'h00;
      endcase
    end

    // register writes; time and setup only take effect while stopped
    if (reg_req.wr) begin
      case (reg_req.addr)
        `CTTC_SECONDS_OFS: begin
          // the compare-mode counter is read-only, so software cannot skip a match
          if (stopped && rtc_mode) begin
            s_d.sec = reg_req.wdata;
          end
        end
        `CTTC_MINUTES_OFS: begin
          if (stopped) begin
            s_d.min = reg_req.wdata;
          end
        end
        `CTTC_HOURS_OFS: begin
          if (stopped) begin
            s_d.hr = reg_req.wdata;
          end
        end
        `CTTC_WEEKDAY_OFS: begin
          if (stopped) begin
            s_d.wk = reg_req.wdata[2:0];
          end
        end
        `CTTC_CTRL_ONE_OFS: begin
          s_d.run_req = reg_req.wdata[`CTTC_C1_RUN_BIT];
          s_d.softclr = reg_req.wdata[`CTTC_C1_SOFTCLR_BIT];
          if (stopped) begin
            s_d.h24    = reg_req.wdata[`CTTC_C1_H24_BIT];
            s_d.pm     = reg_req.wdata[`CTTC_C1_PM_BIT];
            s_d.timing = reg_req.wdata[`CTTC_C1_TIMING_BIT];
          end
        end
        `CTTC_PIE_OFS: begin
          if (stopped) begin
            s_d.pie = reg_req.wdata & `CTTC_PIE_WR_MASK;
          end
        end
        `CTTC_SRC_SEL_OFS: begin
          if (stopped) begin
            s_d.src = reg_req.wdata[3:0];
          end
        end
        `CTTC_IRQ_CTRL_OFS:  s_d.req_flag = reg_req.wdata[`CTTC_IC_REQ_BIT];
        `CTTC_IRQ_MASK_OFS:  s_d.mask = reg_req.wdata[5:0];
        default: begin
        end
      endcase
    end

    // events: gated by enables, set wins over any clear above
    if ((ev & s_q.pie[5:0]) != 6'h00) begin
      s_d.req_flag = 1'b1;
    end
    s_d.status = s_d.status | (ev & s_q.pie[5:0]);
    if (!s_q.pie[`CTTC_PIE_CMP_BIT]) begin
      s_d.status[`CTTC_PIE_CMP_BIT] = s_d.status[`CTTC_PIE_CMP_BIT] & s_q.status[`CTTC_PIE_CMP_BIT];
    end

    // soft clear: zero time, enables, control bits; prescaler clears too
    if (clr) begin
      s_d.sec     = 8'h00;
      s_d.min     = 8'h00;
      s_d.hr      = 8'h00;
      s_d.wk      = 3'd0;
      s_d.pie     = `CTTC_REG_RESET;
      s_d.running = 1'b0;
      s_d.timing  = 1'b0;
      s_d.pm      = 1'b0;
      s_d.h24     = 1'b0;
      s_d.run_req = 1'b0;
      s_d.phase   = cttc_pkg::CTTC_STOPPED;
    end

    s_d.irq = (s_d.status & s_d.mask) != 6'h00;
  end

  // ==========================================================================
  // state register
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_q <= '0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign irq       = s_q.irq;
endmodule : cttc_top

// file: verilog/cttc_map.svh
// register offsets, field positions, reset values and timing counts of the calendar timer
`ifndef CTTC_MAP_SVH
`define CTTC_MAP_SVH
// ==========================================================================
// register offsets (word index on the plain register port)
`define CTTC_SECONDS_OFS     4'h0
`define CTTC_MINUTES_OFS     4'h1
`define CTTC_HOURS_OFS       4'h2
`define CTTC_WEEKDAY_OFS     4'h3
`define CTTC_CTRL_ONE_OFS    4'h4
`define CTTC_PIE_OFS         4'h5
`define CTTC_SRC_SEL_OFS     4'h6
`define CTTC_IRQ_CTRL_OFS    4'h7
`define CTTC_IRQ_STATUS_OFS  4'h8
`define CTTC_IRQ_MASK_OFS    4'h9
// ==========================================================================
// control_reg_one fields
`define CTTC_C1_RUNNING_BIT  1
`define CTTC_C1_TIMING_BIT   3
`define CTTC_C1_SOFTCLR_BIT  4
`define CTTC_C1_PM_BIT       5
`define CTTC_C1_H24_BIT      6
`define CTTC_C1_RUN_BIT      7
`define CTTC_C1_WR_MASK      8'hFC
// periodic_interrupt_enable fields
`define CTTC_PIE_SEC_BIT     0
`define CTTC_PIE_MIN_BIT     1
`define CTTC_PIE_HR_BIT      2
`define CTTC_PIE_DAY_BIT     3
`define CTTC_PIE_WK_BIT      4
`define CTTC_PIE_CMP_BIT     5
`define CTTC_PIE_WR_MASK     8'h3F
// count_source_select_reg fields
`define CTTC_SRC_USE4_BIT    2
`define CTTC_SRC_RTC_BIT     3
// interrupt_control_reg fields
`define CTTC_IC_REQ_BIT      3
`define CTTC_IC_BUSY_BIT     7
// ==========================================================================
// reset values
`define CTTC_REG_RESET       8'h00
`define CTTC_MASK_RESET      8'h00
// ==========================================================================
// timing: update-in-progress window
`define CTTC_BUSY_TIME_US    62500
`define CTTC_CLK_MHZ         100
`define CTTC_BUSY_CYCLES     (`CTTC_BUSY_TIME_US * `CTTC_CLK_MHZ)
`define CTTC_SYNC_STAGES     2
`endif

// file: verilog/cttc_pkg.sv
// types shared by the calendar timer control files
package cttc_pkg;
  // ========================================================================
  // register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } cttc_req_t;

  // periodic event pulses, bit order as the enable register
  typedef struct packed {
    logic cmp;
    logic wk;
    logic day;
    logic hr;
    logic min;
    logic sec;
  } cttc_evt_t;

  // run handshake phase
  typedef enum logic [1:0] {
    CTTC_STOPPED,
    CTTC_STARTING,
    CTTC_RUNNING,
    CTTC_STOPPING
  } cttc_run_t;
endpackage : cttc_pkg

// file: verilog/cttc_prescale.sv
// count source prescaler: picks a tick and divides it into second or compare ticks
`include "cttc_map.svh"
module cttc_prescale #(
  parameter int unsigned SEC_DIV = 32'd256
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire logic       clk_en,
  // control
  input  wire logic       clr,
  input  wire logic       run,
  input  wire logic [3:0] src_sel,
  input  wire logic [3:0] src_ticks,
  // ticks out
  output logic            src_tick,
  output logic            cnt_tick
);
  typedef struct packed {
    logic [31:0] div;
    logic [3:0]  four;
    logic        half;
  } cttc_ps_state_t;

  cttc_ps_state_t s_q;
  cttc_ps_state_t s_d;
  logic           tk;

  // ==========================================================================
  // source selection and division
  always_comb begin
    s_d      = s_q;
    tk       = src_ticks[src_sel[1:0]];
    src_tick = tk;
    cnt_tick = 1'b0;
    if (clr) begin
      s_d = '0;
    end else if (run && tk) begin
      if (src_sel[`CTTC_SRC_RTC_BIT]) begin
        // one second per SEC_DIV source ticks
        if (s_q.div == SEC_DIV - 32'd1) begin
          s_d.div  = '0;
          cnt_tick = 1'b1;
        end else begin
          s_d.div = s_q.div + 32'd1;
        end
      end else begin
        // compare mode counts the source halved, optionally by sixteen more
        s_d.half = ~s_q.half;
        if (s_q.half) begin
          if (!src_sel[`CTTC_SRC_USE4_BIT]) begin
            cnt_tick = 1'b1;
          end else begin
            s_d.four = s_q.four + 4'h1;
            cnt_tick = (s_q.four == 4'hF);
          end
        end
      end
    end
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_q <= '0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end
endmodule : cttc_prescale

// file: testbench/cttc_assertions.sv
// port-level checker for the calendar timer control block
module cttc_assertions (
  // clock and reset
  input wire logic                sys_clk,
  input wire logic                srst,
  input wire logic                clk_en,
  // stimulus and answers
  input wire logic [3:0]          src_ticks,
  input wire cttc_pkg::cttc_req_t reg_req,
  input wire logic [7:0]          reg_rdata,
  input wire logic                irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // ==========================================================================
  // shadows of software writes; setup is only written while stopped
  logic       rd_ok, wr_ok, rdst, wrms, run_q, clr_q, zero_q;
  logic [1:0] sel_q, tk_q;
  logic [7:0] msk_q;
  assign rd_ok = reg_req.rd & clk_en;
  assign wr_ok = reg_req.wr & clk_en;
  assign rdst  = rd_ok && reg_req.addr == 4'h8;
  assign wrms  = wr_ok && (reg_req.addr == 4'h9 || reg_req.addr == 4'h4);
  // tick count saturates at 3, enough to judge a two-tick handshake
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      {run_q, clr_q, zero_q, sel_q, tk_q, msk_q} <= '0;
    end else if (wr_ok) begin
      if (reg_req.addr == 4'h4) begin
        run_q  <= reg_req.wdata[7];
        clr_q  <= reg_req.wdata[4];
        zero_q <= clr_q & ~reg_req.wdata[4];
        tk_q   <= 2'h0;
      end else begin
        zero_q <= 1'b0;
      end
      if (reg_req.addr == 4'h6) sel_q <= reg_req.wdata[1:0];
      if (reg_req.addr == 4'h9) msk_q <= reg_req.wdata;
    end else if (clk_en && src_ticks[sel_q] && tk_q != 2'h3) begin
      tk_q <= tk_q + 2'h1;
    end
  end
  // ==========================================================================
  // properties
  property p_pie_res;
    rd_ok && reg_req.addr == 4'h5 |=> reg_rdata[7:6] == 2'h0;
  endproperty
  a_pie_res: assert property (p_pie_res) else $error("enable reserved bits not zero");
  property p_run_on;
    rd_ok && reg_req.addr == 4'h4 && run_q && tk_q == 2'h3 |=> reg_rdata[1];
  endproperty
  a_run_on: assert property (p_run_on) else $error("running flag late after start");
  property p_run_off;
    rd_ok && reg_req.addr == 4'h4 && !run_q && tk_q == 2'h3 |=> !reg_rdata[1];
  endproperty
  a_run_off: assert property (p_run_off) else $error("running flag late after stop");
  property p_irq_hold;
    irq && !rdst && !wrms && !$past(rdst) && !$past(wrms) |=> irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped without clear");
  property p_clear;
    zero_q && rd_ok && (reg_req.addr <= 4'h3 || reg_req.addr == 4'h5) |=> reg_rdata == 8'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("register not zero after soft clear");
  property p_irq_src;
    $rose(irq) |-> (msk_q | $past(msk_q)) != 8'h00;
  endproperty
  a_irq_src: assert property (p_irq_src) else $error("irq rose with mask empty");
  property p_mask_off;
    wr_ok && reg_req.addr == 4'h9 && reg_req.wdata == 8'h00 |-> ##[1:2] !irq;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("irq stayed high with mask empty");
  property p_stat_res;
    rdst |=> reg_rdata[7:6] == 2'h0;
  endproperty
  a_stat_res: assert property (p_stat_res) else $error("status reserved bits not zero");
  // main scenarios reached
  c_run_on: cover property (rd_ok && reg_req.addr == 4'h4 && run_q && tk_q == 2'h3);
  c_irq: cover property ($rose(irq));
  c_clear: cover property (zero_q && rd_ok);
endmodule : cttc_assertions

bind cttc_top cttc_assertions u_chk (
  .sys_clk(sys_clk), .srst(srst), .clk_en(clk_en), .src_ticks(src_ticks),
  .reg_req(reg_req), .reg_rdata(reg_rdata), .irq(irq));

// file: testbench/calendar_timer_control_tb.sv
// self-checking bench for the calendar timer control block
module calendar_timer_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                sys_clk;
  logic                srst;
  logic                clk_en;
  logic [3:0]          src_ticks = 4'h0;
  logic [1:0]          tdiv = 2'h0;
  cttc_pkg::cttc_req_t req;
  logic [7:0]          rdata;
  logic                irq;
  logic [7:0]          v;
  int                  bad_count;
  int                  n_compared;

  // short busy window and second keep the run brief
  cttc_top #(.BUSY_CYCLES(20), .SEC_DIV(16)) uut (
    .sys_clk(sys_clk), .srst(srst), .clk_en(clk_en), .src_ticks(src_ticks),
    .reg_req(req), .reg_rdata(rdata), .irq(irq));

  // ==========================================================================
  // clock and a source tick on every fourth cycle
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    tdiv <= tdiv + 2'h1;
    src_ticks <= (tdiv == 2'h3) ? 4'hF : 4'h0;
  end

  // ==========================================================================
  // bus and compare helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask : rd
  task automatic rc(input logic [3:0] a, input logic [7:0] e);
    rd(a, v);
    chk(v, e);
  endtask : rc
  // bounded wait for the interrupt, then judge it
  task automatic wirq(input int n);
    for (int i = 0; i < n && irq !== 1'b1; i++) @(posedge sys_clk);
    chk({7'h0, irq}, 8'h01);
  endtask : wirq

  // ==========================================================================
  // scenarios
  task automatic t_reset;
    for (int a = 0; a < 10; a++) rc(4'(a), 8'h00);
    rc(4'hF, 8'h00);
  endtask : t_reset
  // one second step rolls every field at once
  task automatic t_rtc;
    wr(4'h6, 8'h08);
    wr(4'h4, 8'h48);
    wr(4'h0, 8'h59);
    wr(4'h1, 8'h59);
    wr(4'h2, 8'h23);
    wr(4'h3, 8'h06);
    wr(4'h9, 8'h1F);
    wr(4'h5, 8'h1F);
    wr(4'h4, 8'hC8);
    repeat (16) @(posedge sys_clk);
    rc(4'h4, 8'hCA);
    wirq(100);
    rc(4'h7, 8'h88);
    rc(4'h8, 8'h1F);
    // time read right after the request, well before the next second
    rc(4'h0, 8'h00);
    rc(4'h1, 8'h00);
    rc(4'h2, 8'h00);
    rc(4'h3, 8'h00);
    rd(4'h3, v);
    rc(4'h3, v);
    wr(4'h2, 8'h11);
    rc(4'h2, 8'h00);
  endtask : t_rtc
  // busy window length, measured from a clean rise
  task automatic t_busy;
    int k;
    k = 0;
    v = 8'h80;
    for (int i = 0; i < 60 && v[7] !== 1'b0; i++) rd(4'h7, v);
    for (int i = 0; i < 60 && v[7] !== 1'b1; i++) rd(4'h7, v);
    while (v[7] === 1'b1 && k < 40) begin
      rd(4'h7, v);
      k++;
    end
    chk({7'h0, k >= 8 && k <= 11}, 8'h01);
  endtask : t_busy
  task automatic t_stop;
    wr(4'h4, 8'h48);
    repeat (16) @(posedge sys_clk);
    rc(4'h4, 8'h48);
    rd(4'h0, v);
    repeat (150) @(posedge sys_clk);
    chk(rdata, 8'h00);
    rc(4'h0, v);
  endtask : t_stop
  task automatic t_clear;
    wr(4'h4, 8'h10);
    wr(4'h4, 8'h00);
    for (int a = 0; a < 6; a++) rc(4'(a), 8'h00);
  endtask : t_clear
  // compare value 3 wraps the counter every 32 cycles
  task automatic t_cmp;
    wr(4'h6, 8'h00);
    // seconds status is sticky from the calendar run; soft clear leaves it
    rc(4'h8, 8'h01);
    wr(4'h1, 8'h03);
    wr(4'h9, 8'h20);
    wr(4'h5, 8'h20);
    wr(4'h4, 8'h80);
    wirq(80);
    // enable low: a status read is ignored, so irq and status must hold
    @(posedge sys_clk);
    clk_en <= 1'b0;
    rd(4'h8, v);
    chk({7'h0, irq}, 8'h01);
    @(posedge sys_clk);
    clk_en <= 1'b1;
    wr(4'h9, 8'h00);
    repeat (2) @(posedge sys_clk);
    chk({7'h0, irq}, 8'h00);
    rc(4'h8, 8'h20);
    rd(4'h0, v);
    chk({7'h0, v <= 8'h03}, 8'h01);
    wr(4'h4, 8'h00);
    repeat (16) @(posedge sys_clk);
    rd(4'h0, v);
    wr(4'h0, 8'h07);
    rc(4'h0, v);
    wr(4'h5, 8'h00);
    wr(4'h4, 8'h80);
    repeat (80) @(posedge sys_clk);
    rc(4'h8, 8'h00);
    wr(4'h4, 8'h00);
  endtask : t_cmp

  // ==========================================================================
  // verdict, main sequence and watchdog
  task automatic finish_test;
    if (bad_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    srst = 1'b1;
    clk_en = 1'b1;
    req = '0;
    bad_count = 0;
    n_compared = 0;
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    t_reset;
    t_rtc;
    t_busy;
    t_stop;
    t_clear;
    t_cmp;
    finish_test;
  end
  // whole run needs well under a thousand cycles
  initial begin
    #200000;
    bad_count++;
    finish_test;
  end
endmodule : calendar_timer_control_tb
